// >>> hw/cdt_core.v
// execution core for data transfer, stack, bit and flag instructions, apb controlled
`timescale 1ns/100ps
`include "cdt_defines.vh"

// What this block does
// - branch_on_irq_enabled jumps by offset plus one
// - branch_on_irq_disabled jumps by offset plus one
// - indirect load then pointer plus one
// - pointer minus one then indirect load
// - displaced load from pointer plus q
// - direct load from instruction address
// - indirect store then pointer plus one
// - pointer minus one then indirect store
// - displaced store to pointer plus q
// - direct store to instruction address
// - program memory load via third pointer, three cycles
// - push source register, two cycles
// - pop destination register, two cycles
// - set one i/o register bit
// - clear one i/o register bit
// - rotate left through carry, flags updated
// - rotate right through carry, flags updated
// - copy register bit into transfer flag
// - copy transfer flag into register bit
// - force overflow flag one or zero
// - force signed flag one or zero
module cdt_core (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [15:0] dmem_addr,
  output reg  [7:0]  dmem_wdata,
  output reg         dmem_we,
  output reg         dmem_re,
  input  wire [7:0]  dmem_rdata,
  output reg  [15:0] pmem_addr,
  output reg         pmem_re,
  input  wire [15:0] pmem_rdata,
  output reg  [4:0]  io_addr,
  output reg  [7:0]  io_wdata,
  output reg         io_we,
  input  wire [7:0]  io_rdata,
  output reg         busy
);

  reg  [7:0]  gpr [0:31];
  reg  [7:0]  status_flags_register;
  reg  [15:0] pc;
  reg  [15:0] sp;
  reg  [4:0]  reg_index;
  reg  [31:0] instr;
  reg  [15:0] ea;
  reg  [1:0]  cyc;
  reg  [1:0]  ncyc;
  reg         taken;
  reg  [15:0] pm_word;

  reg  [15:0] next_ea;
  reg  [1:0]  next_ncyc;
  reg         next_taken;
  reg  [31:0] rd_mux;
  reg         mapped;

  wire        access = psel & penable;
  wire        wr_req = access & pwrite;
  wire        go     = wr_req & (paddr == `CDT_OFS_EXEC) & ~busy;
  wire        last   = busy & (cyc == ncyc - 2'd1);

  wire [4:0]  d_op   = pwdata[`CDT_F_OP];
  wire [4:0]  d_reg  = pwdata[`CDT_F_REG];
  wire [1:0]  d_ptr  = pwdata[`CDT_F_PTR];
  wire [1:0]  d_mode = pwdata[`CDT_F_MODE];
  wire [4:0]  op     = instr[`CDT_F_OP];
  wire [4:0]  fr     = instr[`CDT_F_REG];
  wire [1:0]  fptr   = instr[`CDT_F_PTR];
  wire [1:0]  fmode  = instr[`CDT_F_MODE];
  wire [6:0]  k      = instr[`CDT_F_K];

  wire [7:0]  bu_result;
  wire [7:0]  bu_flags;
  wire        io_op  = (op == `CDT_OP_IOSET) | (op == `CDT_OP_IOCLR);

  // pointer pair base register
  function [4:0] ptr_lo;
    input [1:0] sel;
    begin
      case (sel)
        `CDT_PTR_Y: ptr_lo = `CDT_Y_LO;
        `CDT_PTR_Z: ptr_lo = `CDT_Z_LO;
        default:    ptr_lo = `CDT_X_LO;
      endcase
    end
  endfunction

  // pointer pair value, low byte in the even register
  function [15:0] ptr_of;
    input [1:0] sel;
    reg   [4:0] b;
    begin
      b      = ptr_lo(sel);
      ptr_of = {gpr[b + 5'h01], gpr[b]};
    end
  endfunction

  function is_mem_op;
    input [4:0] o;
    begin
      is_mem_op = (o >= `CDT_OP_LDI) && (o <= `CDT_OP_IOCLR) && (o != `CDT_OP_PMLD);
    end
  endfunction

  // only rotates, bit transfers and the forced flags write the status flags
  function is_flag_op;
    input [4:0] o;
    begin
      is_flag_op = (o >= `CDT_OP_ROTL) && (o <= `CDT_OP_SCLR);
    end
  endfunction

  // program word to byte, an odd pointer picks the high byte
  function [7:0] pm_byte;
    input [15:0] word;
    input        odd;
    begin
      pm_byte = odd ? word[15:8] : word[7:0];
    end
  endfunction

  // seven bit signed offset, sign extended to the program counter width
  function [15:0] branch_target;
    input [15:0] base;
    input [6:0]  ofs;
    begin
      branch_target = base + {{9{ofs[6]}}, ofs} + 16'h0001;
    end
  endfunction

  // effective address and cycle count decoded from the incoming instruction
  always @* begin
    next_ea    = 16'h0000;
    next_taken = 1'b0;
    next_ncyc  = `CDT_CYC_ONE;
    case (d_op)
      `CDT_OP_BR_IEN:  next_taken = status_flags_register[`CDT_FL_I];
      `CDT_OP_BR_IDIS: next_taken = ~status_flags_register[`CDT_FL_I];
      `CDT_OP_LDI, `CDT_OP_STI:
        next_ea = (d_mode == `CDT_MODE_PRE) ? ptr_of(d_ptr) - 16'h0001 : ptr_of(d_ptr);
      `CDT_OP_LDDY, `CDT_OP_STDY: next_ea = ptr_of(`CDT_PTR_Y) + {10'h000, pwdata[`CDT_F_Q]};
      `CDT_OP_LDDZ, `CDT_OP_STDZ: next_ea = ptr_of(`CDT_PTR_Z) + {10'h000, pwdata[`CDT_F_Q]};
      `CDT_OP_LD_DIR, `CDT_OP_ST_DIR: next_ea = pwdata[`CDT_F_WORD2];
      `CDT_OP_PUSH: next_ea = sp;
      `CDT_OP_POP:  next_ea = sp + 16'h0001;
      `CDT_OP_PMLD: next_ea = ptr_of(`CDT_PTR_Z);
      default:      next_ea = 16'h0000;
    endcase
    if (d_op == `CDT_OP_PMLD)
      next_ncyc = `CDT_CYC_PMEM;
    else if (is_mem_op(d_op) || next_taken)
      next_ncyc = `CDT_CYC_MEM;
  end

  cdt_bit_unit u_bit (
    .op        (op),
    .operand   (io_op ? io_rdata : gpr[fr]),
    .bit_sel   (instr[`CDT_F_BIT]),
    .flags_in  (status_flags_register),
    .result    (bu_result),
    .flags_out (bu_flags)
  );

  // sequencer and memory strobes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy       <= 1'b0;
      cyc        <= 2'd0;
      ncyc       <= `CDT_CYC_ONE;
      taken      <= 1'b0;
      instr      <= 32'h00000000;
      ea         <= 16'h0000;
      dmem_addr  <= 16'h0000;
      dmem_wdata <= 8'h00;
      dmem_we    <= 1'b0;
      dmem_re    <= 1'b0;
      pmem_addr  <= 16'h0000;
      pmem_re    <= 1'b0;
      pm_word    <= 16'h0000;
      io_addr    <= 5'h00;
      io_wdata   <= 8'h00;
      io_we      <= 1'b0;
    end else begin
      dmem_we <= 1'b0;
      dmem_re <= 1'b0;
      pmem_re <= 1'b0;
      io_we   <= 1'b0;
      if (go) begin
        busy  <= 1'b1;
        cyc   <= 2'd0;
        ncyc  <= next_ncyc;
        taken <= next_taken;
        instr <= pwdata;
        ea    <= next_ea;
        // strobes launch with the instruction so each access fits the cycle budget
        case (d_op)
          `CDT_OP_LDI, `CDT_OP_LDDY, `CDT_OP_LDDZ, `CDT_OP_LD_DIR, `CDT_OP_POP: begin
            dmem_addr <= next_ea;
            dmem_re   <= 1'b1;
          end
          `CDT_OP_STI, `CDT_OP_STDY, `CDT_OP_STDZ, `CDT_OP_ST_DIR, `CDT_OP_PUSH: begin
            dmem_addr  <= next_ea;
            dmem_wdata <= gpr[d_reg];
            dmem_we    <= 1'b1;
          end
          `CDT_OP_PMLD: begin
            pmem_addr <= {1'b0, next_ea[15:1]};
            pmem_re   <= 1'b1;
          end
          `CDT_OP_IOSET, `CDT_OP_IOCLR: io_addr <= pwdata[`CDT_F_IO];
          default: io_addr <= io_addr;
        endcase
      end else if (busy) begin
        cyc <= cyc + 2'd1;
        if (last)
          busy <= 1'b0;
        // i/o space reads combinationally, so the modified byte is written in cycle two
        if (io_op && cyc == 2'd0) begin
          io_wdata <= bu_result;
          io_we    <= 1'b1;
        end
        if (op == `CDT_OP_PMLD && cyc == 2'd1)
          pm_word <= pmem_rdata;
      end
    end
  end

  // register file: software access when idle, instruction results at the last cycle
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 32; i = i + 1)
        gpr[i] <= 8'h00;
    end else if (!busy) begin
      if (wr_req && paddr == `CDT_OFS_RDAT)
        gpr[reg_index] <= pwdata[7:0];
    end else if (last) begin
      case (op)
        `CDT_OP_LDI, `CDT_OP_STI: begin
          if (fmode == `CDT_MODE_POST) begin
            {gpr[ptr_lo(fptr) + 5'h01], gpr[ptr_lo(fptr)]} <= ea + 16'h0001;
          end else if (fmode == `CDT_MODE_PRE) begin
            {gpr[ptr_lo(fptr) + 5'h01], gpr[ptr_lo(fptr)]} <= ea;
          end
          if (op == `CDT_OP_LDI)
            gpr[fr] <= dmem_rdata;
        end
        `CDT_OP_LDDY, `CDT_OP_LDDZ, `CDT_OP_LD_DIR, `CDT_OP_POP:
          gpr[fr] <= dmem_rdata;
        `CDT_OP_PMLD: begin
          if (instr[`CDT_PM_INC])
            {gpr[`CDT_Z_LO + 5'h01], gpr[`CDT_Z_LO]} <= ea + 16'h0001;
          if (instr[`CDT_PM_R0])
            gpr[`CDT_R0] <= pm_byte(pm_word, ea[0]);
          else
            gpr[fr] <= pm_byte(pm_word, ea[0]);
        end
        `CDT_OP_ROTL, `CDT_OP_ROTR, `CDT_OP_TLOAD:
          gpr[fr] <= bu_result;
        default: gpr[fr] <= gpr[fr];
      endcase
    end
  end

  // status flags, program counter, stack pointer and register index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register <= `CDT_RST_FLAGS;
      pc                    <= `CDT_RST_PC;
      sp                    <= `CDT_RST_SP;
      reg_index             <= 5'h00;
    end else if (!busy) begin
      if (wr_req && paddr == `CDT_OFS_FLAGS)
        status_flags_register <= pwdata[7:0];
      if (wr_req && paddr == `CDT_OFS_PC)
        pc <= pwdata[15:0];
      if (wr_req && paddr == `CDT_OFS_SP)
        sp <= pwdata[15:0];
      if (wr_req && paddr == `CDT_OFS_RIDX)
        reg_index <= pwdata[4:0];
    end else if (last) begin
      if (taken)
        pc <= branch_target(pc, k);
      else if (op == `CDT_OP_LD_DIR || op == `CDT_OP_ST_DIR)
        pc <= pc + 16'h0002;
      else
        pc <= pc + 16'h0001;
      if (op == `CDT_OP_PUSH)
        sp <= sp - 16'h0001;
      if (op == `CDT_OP_POP)
        sp <= ea;
      if (is_flag_op(op))
        status_flags_register <= bu_flags;
    end
  end

  // apb slave: zero wait states, read data captured in the setup phase
  always @* begin
    mapped = 1'b1;
    case (paddr)
      `CDT_OFS_EXEC:  rd_mux = instr;
      `CDT_OFS_STAT:  rd_mux = {28'h0000000, taken, cyc, busy};
      `CDT_OFS_FLAGS: rd_mux = {24'h000000, status_flags_register};
      `CDT_OFS_PC:    rd_mux = {16'h0000, pc};
      `CDT_OFS_SP:    rd_mux = {16'h0000, sp};
      `CDT_OFS_RIDX:  rd_mux = {27'h0000000, reg_index};
      `CDT_OFS_RDAT:  rd_mux = {24'h000000, gpr[reg_index]};
      default: begin
        rd_mux = 32'h00000000;
        mapped = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel && !penable && !pwrite)
      prdata <= rd_mux;
  end

  assign pready  = 1'b1;
  // unmapped addresses fail every access
  wire        bad_addr  = access & ~mapped;
  // state changes are refused while an instruction runs; status stays read-only
  wire        bad_write = wr_req & busy & (paddr != `CDT_OFS_STAT);
  assign pslverr = bad_addr | bad_write;

endmodule // cdt_core

// >>> hw/cdt_defines.vh
// constants for the data transfer and bit operation core
`ifndef CDT_DEFINES_VH
`define CDT_DEFINES_VH
`define CDT_OFS_EXEC   8'h00
`define CDT_OFS_STAT   8'h04
`define CDT_OFS_FLAGS  8'h08
`define CDT_OFS_PC     8'h0c
`define CDT_OFS_SP     8'h10
`define CDT_OFS_RIDX   8'h14
`define CDT_OFS_RDAT   8'h18
`define CDT_RST_PC     16'h0000
`define CDT_RST_SP     16'h00ff
`define CDT_RST_FLAGS  8'h00
`define CDT_FL_C       0
`define CDT_FL_Z       1
`define CDT_FL_N       2
`define CDT_FL_V       3
`define CDT_FL_S       4
`define CDT_FL_T       6
`define CDT_FL_I       7
`define CDT_F_OP       15:11
`define CDT_F_REG      10:6
`define CDT_F_PTR      5:4
`define CDT_F_MODE     1:0
`define CDT_F_Q        5:0
`define CDT_F_BIT      2:0
`define CDT_F_K        6:0
`define CDT_F_IO       10:6
`define CDT_F_WORD2    31:16
`define CDT_PM_INC     0
`define CDT_PM_R0      1
`define CDT_CYC_ONE    2'd1
`define CDT_CYC_MEM    2'd2
`define CDT_CYC_PMEM   2'd3
`define CDT_OP_NOP     5'h00
`define CDT_OP_BR_IEN  5'h01
`define CDT_OP_BR_IDIS 5'h02
`define CDT_OP_LDI     5'h03
`define CDT_OP_LDDY    5'h04
`define CDT_OP_LDDZ    5'h05
`define CDT_OP_LD_DIR  5'h06
`define CDT_OP_STI     5'h07
`define CDT_OP_STDY    5'h08
`define CDT_OP_STDZ    5'h09
`define CDT_OP_ST_DIR  5'h0a
`define CDT_OP_PMLD    5'h0b
`define CDT_OP_PUSH    5'h0c
`define CDT_OP_POP     5'h0d
`define CDT_OP_IOSET   5'h0e
`define CDT_OP_IOCLR   5'h0f
`define CDT_OP_ROTL    5'h10
`define CDT_OP_ROTR    5'h11
`define CDT_OP_TSTORE  5'h12
`define CDT_OP_TLOAD   5'h13
`define CDT_OP_VSET    5'h14
`define CDT_OP_VCLR    5'h15
`define CDT_OP_SSET    5'h16
`define CDT_OP_SCLR    5'h17
`define CDT_PTR_Y      2'h2
`define CDT_PTR_Z      2'h3
`define CDT_MODE_POST  2'h1
`define CDT_MODE_PRE   2'h2
`define CDT_X_LO       5'h1a
`define CDT_Y_LO       5'h1c
`define CDT_Z_LO       5'h1e
`define CDT_R0         5'h00
`endif

// >>> hw/cdt_bit_unit.v
// rotate, bit transfer, i/o bit modify and flag force datapath
`timescale 1ns/100ps
`include "cdt_defines.vh"
module cdt_bit_unit (
  input  wire [4:0] op,
  input  wire [7:0] operand,
  input  wire [2:0] bit_sel,
  input  wire [7:0] flags_in,
  output reg  [7:0] result,
  output reg  [7:0] flags_out
);
  always @* begin
    result    = operand;
    flags_out = flags_in;
    case (op)
      `CDT_OP_ROTL: begin
        result = {operand[6:0], flags_in[`CDT_FL_C]};
        flags_out[`CDT_FL_C] = operand[7];
        flags_out[`CDT_FL_N] = result[7];
        flags_out[`CDT_FL_Z] = (result == 8'h00);
        flags_out[`CDT_FL_V] = result[7] ^ operand[7];
      end
      `CDT_OP_ROTR: begin
        result = {flags_in[`CDT_FL_C], operand[7:1]};
        flags_out[`CDT_FL_C] = operand[0];
        flags_out[`CDT_FL_N] = result[7];
        flags_out[`CDT_FL_Z] = (result == 8'h00);
        flags_out[`CDT_FL_V] = result[7] ^ operand[0];
      end
      `CDT_OP_TSTORE: flags_out[`CDT_FL_T] = operand[bit_sel];
      `CDT_OP_TLOAD:  result[bit_sel] = flags_in[`CDT_FL_T];
      `CDT_OP_IOSET:  result[bit_sel] = 1'b1;
      `CDT_OP_IOCLR:  result[bit_sel] = 1'b0;
      `CDT_OP_VSET:   flags_out[`CDT_FL_V] = 1'b1;
      `CDT_OP_VCLR:   flags_out[`CDT_FL_V] = 1'b0;
      `CDT_OP_SSET:   flags_out[`CDT_FL_S] = 1'b1;
      `CDT_OP_SCLR:   flags_out[`CDT_FL_S] = 1'b0;
      default: result = operand;
    endcase
  end
endmodule // cdt_bit_unit

// >>> sim/cdt_mem_model.sv
// data, program and i/o memory model facing the core
`timescale 1ns/100ps
module cdt_mem_model (
  input  wire        pclk,
  input  wire [15:0] dmem_addr,
  input  wire [7:0]  dmem_wdata,
  input  wire        dmem_we,
  input  wire        dmem_re,
  output reg  [7:0]  dmem_rdata,
  input  wire [15:0] pmem_addr,
  input  wire        pmem_re,
  output reg  [15:0] pmem_rdata,
  input  wire [4:0]  io_addr,
  input  wire [7:0]  io_wdata,
  input  wire        io_we,
  output wire [7:0]  io_rdata
);
  logic [7:0] dm [65536];
  logic [7:0] io [32];
  initial begin
    for (int i = 0; i < 65536; i++) dm[i] = i[7:0] ^ i[15:8] ^ 8'h5a;
    for (int i = 0; i < 32; i++) io[i] = i[7:0] * 8'h25;
    dmem_rdata = 8'h00;
    pmem_rdata = 16'h0000;
  end
  assign io_rdata = io[io_addr];
  // outside the one-cycle answer slot the data toggles, so a sample one cycle late never matches by luck
  always @(posedge pclk) begin
    dmem_rdata <= dmem_re ? dm[dmem_addr] : ~dmem_rdata;
    pmem_rdata <= pmem_re ? {pmem_addr[7:0] ^ 8'h3c, pmem_addr[15:8] ^ pmem_addr[7:0]} : ~pmem_rdata;
    if (dmem_we) dm[dmem_addr] <= dmem_wdata;
    if (io_we) io[io_addr] <= io_wdata;
  end
endmodule // cdt_mem_model

// >>> sim/cdt_core_props.sv
// assertions on instruction timing and memory strobes of the core
`timescale 1ns/100ps
`include "cdt_defines.vh"
module cdt_core_props (
  input wire        pclk,
  input wire        presetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [31:0] pwdata,
  input wire [15:0] dmem_addr,
  input wire        dmem_we,
  input wire        dmem_re,
  input wire        pmem_re,
  input wire [7:0]  io_wdata,
  input wire        io_we,
  input wire [7:0]  io_rdata,
  input wire        busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       go = psel & penable & pwrite & (paddr == `CDT_OFS_EXEC) & ~busy;
  wire [4:0] op = pwdata[15:11];
  property p_two;
    go && ((op >= 5'h03 && op <= 5'h0a) || (op >= 5'h0c && op <= 5'h0f)) |=> busy [*2] ##1 !busy;
  endproperty
  a_two: assert property (p_two) else $error("memory op not two cycles");
  property p_one;
    go && op >= 5'h10 && op <= 5'h17 |=> busy ##1 !busy;
  endproperty
  a_one: assert property (p_one) else $error("bit or flag op not one cycle");
  property p_lpm;
    go && op == 5'h0b |=> busy [*3] ##1 !busy;
  endproperty
  a_lpm: assert property (p_lpm) else $error("program load not three cycles");
  property p_fetch;
    go && op == 5'h0b |=> pmem_re && !dmem_re ##1 !pmem_re;
  endproperty
  a_fetch: assert property (p_fetch) else $error("program fetch strobe wrong");
  property p_direct;
    go && (op == 5'h06 || op == 5'h0a) |=> dmem_we == $past(op == 5'h0a) && dmem_re != dmem_we
      && dmem_addr == $past(pwdata[31:16]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct access address wrong");
  property p_load;
    go && op >= 5'h03 && op <= 5'h06 |=> dmem_re && !dmem_we ##1 !dmem_re;
  endproperty
  a_load: assert property (p_load) else $error("load read strobe wrong");
  property p_set;
    go && op == 5'h0e |=> ##1 io_we && io_wdata == ($past(io_rdata) | (8'h01 << $past(pwdata[2:0], 2)));
  endproperty
  a_set: assert property (p_set) else $error("io bit set value wrong");
  property p_clr;
    go && op == 5'h0f |=> ##1 io_we && io_wdata == ($past(io_rdata) & ~(8'h01 << $past(pwdata[2:0], 2)));
  endproperty
  a_clr: assert property (p_clr) else $error("io bit clear value wrong");
endmodule // cdt_core_props
bind cdt_core cdt_core_props cdt_core_props_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .dmem_addr, .dmem_we, .dmem_re, .pmem_re, .io_wdata, .io_we, .io_rdata, .busy);

// >>> sim/tb.sv
// self-checking bench for the data transfer and bit operation core
`timescale 1ns/100ps
`include "cdt_defines.vh"
`define chk(x, y) begin checks_done++; if ((x) !== (y)) begin mismatches++; $display("MISMATCH %0t got %h want %h", $time, x, y); end end
module tb;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err_exp = 0;
  logic [7:0]  paddr = 0, f, rx, nf, dmem_wdata, dmem_rdata, io_wdata, io_rdata;
  logic [15:0] ptr, ad, np, dmem_addr, pmem_addr, pmem_rdata;
  logic [31:0] pwdata = 0, prdata, v, lo, s = 32'hc1c0;
  logic [35:0] e, q[$];
  logic [4:0]  io_addr;
  logic        dmem_we, dmem_re, pmem_re, io_we, busy;
  int          mismatches = 0, checks_done = 0, o, m, p, n, a;
  int          ops[6] = '{3, 7, 4, 5, 8, 9};
  cdt_core cdt_core_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .pmem_addr, .pmem_re, .pmem_rdata, .io_addr,
    .io_wdata, .io_we, .io_rdata, .busy);
  cdt_mem_model cdt_mem_model_i (.pclk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .dmem_rdata, .pmem_addr,
    .pmem_re, .pmem_rdata, .io_addr, .io_wdata, .io_we, .io_rdata);
  initial forever #20 pclk = ~pclk;
  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    final_report;
  end
  function automatic logic [31:0] rnd();
    s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic logic [7:0] dv(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5a;
  endfunction
  function automatic logic [7:0] pv(input logic [15:0] z);
    logic [15:0] w;
    w = {z[8:1] ^ 8'h3c, {1'b0, z[15:9]} ^ z[8:1]};
    return z[0] ? w[15:8] : w[7:0];
  endfunction
  // an unexpected write finds the queue empty and fails against all ones
  always @(posedge pclk) if (dmem_we || io_we || (psel && penable && pready && !pwrite)) begin
    e = q.size() ? q.pop_front() : '1;
    `chk(dmem_we ? {4'h1, dmem_addr, 8'h00, dmem_wdata} : io_we ? {4'h2, 19'h0, io_addr, io_wdata} : {4'h3, prdata}, e)
  end
  task apb(input logic w, input logic [7:0] ad_i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= ad_i;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    `chk(pslverr, err_exp)
    psel <= 0;
    penable <= 0;
  endtask
  task rd(input logic [7:0] ad_i, input logic [31:0] x);
    q.push_back({4'h3, x});
    apb(0, ad_i, 0);
  endtask
  task ex(input logic [31:0] w);
    apb(1, `CDT_OFS_EXEC, w);
    @(posedge pclk);
    while (busy === 1'b1) @(posedge pclk);
  endtask
  task setr(input int i, input logic [7:0] x);
    apb(1, `CDT_OFS_RIDX, i);
    apb(1, `CDT_OFS_RDAT, x);
  endtask
  task chkr(input int i, input logic [7:0] x);
    apb(1, `CDT_OFS_RIDX, i);
    rd(`CDT_OFS_RDAT, x);
  endtask
  task final_report;
    `chk(q.size(), 0)
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    rd(`CDT_OFS_SP, 32'h00ff);
    for (int i = 0; i < 2; i++) begin
      apb(1, `CDT_OFS_FLAGS, i << 7);
      apb(1, `CDT_OFS_PC, 40);
      ex({16'h0, 5'h01, 11'h07d});
      ex({16'h0, 5'h02, 11'h005});
      rd(`CDT_OFS_PC, i ? 39 : 47);
      rd(`CDT_OFS_FLAGS, i << 7);
    end
    for (int j = 0; j < 12; j++) begin
      o = ops[j % 6];
      m = 1 + j / 6;
      p = (o % 4 == 3) ? m : o % 4 + 2;
      n = 24 + 2 * p;
      ptr = rnd();
      v = rnd();
      lo = (o % 4 == 3) ? m * 17 : rnd() & 63;
      ad = (o % 4 == 3) ? (m == 2 ? ptr - 1 : ptr) : ptr + lo[5:0];
      np = (o % 4 == 3) ? (m == 2 ? ptr - 1 : ptr + 1) : ptr;
      setr(n, ptr[7:0]);
      setr(n + 1, ptr[15:8]);
      setr(5, v[7:0]);
      if (o > 6) q.push_back({4'h1, ad, 8'h00, v[7:0]});
      ex({16'h0, o[4:0], 5'd5, lo[5:0]});
      chkr(5, o > 6 ? v[7:0] : dv(ad));
      chkr(n, np[7:0]);
      chkr(n + 1, np[15:8]);
    end
    ad = rnd();
    ex({ad, 5'h06, 5'd7, 6'h0});
    chkr(7, dv(ad));
    q.push_back({4'h1, ad + 16'h1, 8'h00, dv(ad)});
    ex({ad + 16'h1, 5'h0a, 5'd7, 6'h0});
    for (int k = 0; k < 3; k++) begin
      ptr = rnd();
      np = ptr + k[0];
      setr(30, ptr[7:0]);
      setr(31, ptr[15:8]);
      ex({16'h0, 5'h0b, 5'd9, 4'h0, k[1:0]});
      chkr(k[1] ? 0 : 9, pv(ptr));
      chkr(30, np[7:0]);
    end
    v = rnd();
    setr(9, v[7:0]);
    q.push_back({4'h1, 16'h00ff, 8'h00, v[7:0]});
    ex({16'h0, 5'h0c, 5'd9, 6'h0});
    rd(`CDT_OFS_SP, 32'h00fe);
    ex({16'h0, 5'h0d, 5'd10, 6'h0});
    chkr(10, v[7:0]);
    rd(`CDT_OFS_SP, 32'h00ff);
    for (int j = 0; j < 8; j++) begin
      a = 4 * j + 1;
      q.push_back({4'h2, 19'h0, a[4:0], (a[7:0] * 8'h25) | (8'h01 << j)});
      ex({16'h0, 5'h0e, a[4:0], 3'h0, j[2:0]});
      q.push_back({4'h2, 19'h0, a[4:0], (a[7:0] * 8'h25) & ~(8'h01 << j)});
      ex({16'h0, 5'h0f, a[4:0], 3'h0, j[2:0]});
    end
    // ops 10..17 in turn; bit select follows the loop index
    for (int j = 0; j < 8; j++) begin
      v = rnd();
      f = rnd();
      rx = j == 0 ? {v[6:0], f[0]} : j == 1 ? {f[0], v[7:1]} : v[7:0];
      if (j == 3) rx[3] = f[6];
      nf = f;
      if (j < 2) nf[3:0] = {rx[7] ^ v[j ? 0 : 7], rx[7], rx == 8'h00, v[j ? 0 : 7]};
      if (j == 2) nf[6] = v[2];
      if (j > 3) nf[3 + j / 6] = ~j[0];
      setr(3, v[7:0]);
      apb(1, `CDT_OFS_FLAGS, f);
      ex({16'h0, 2'b10, j[2:0], 5'd3, 3'h0, j[2:0]});
      chkr(3, rx);
      rd(`CDT_OFS_FLAGS, nf);
    end
    err_exp = 1;
    rd(8'h40, 0);
    err_exp = 0;
    apb(1, `CDT_OFS_EXEC, {16'h0, 5'h0b, 11'h0});
    // second instruction arrives while the first runs and must be refused
    err_exp = 1;
    apb(1, `CDT_OFS_EXEC, {16'h1234, 5'h0a, 11'h0});
    err_exp = 0;
    repeat (4) @(posedge pclk);
    final_report;
  end
endmodule // tb
